/* File: verilog/backlash_comp_pkg.sv */
// constants, register map and types of the backlash compensation stage
package backlash_comp_pkg;

    // ************************************************
    // register map
    // ************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_DIRECTION = 8'h00;
    localparam logic [7:0] OFS_AMOUNT = 8'h04;
    localparam logic [7:0] OFS_TIME_CONST = 8'h08;
    localparam logic [7:0] OFS_APPLIED = 8'h0C;
    localparam logic [7:0] OFS_LIMIT = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // ************************************************
    // reset values and ranges
    // ************************************************
    localparam logic [15:0] DIR_RESET = 16'h0000;
    localparam logic signed [31:0] AMOUNT_RESET = 32'sh00000000;
    localparam logic [15:0] TC_RESET = 16'h0000;
    localparam logic signed [31:0] AMOUNT_MAX = 32'sd500000;
    localparam logic signed [31:0] AMOUNT_MIN = -32'sd500000;
    localparam logic DIR_FORWARD = 1'b0;
    localparam logic DIR_REVERSE = 1'b1;

    // ************************************************
    // status bits
    // ************************************************
    localparam int ST_ACTIVE_DIR_BIT = 0;
    localparam int ST_COMP_ON_BIT = 1;
    localparam int ST_OVER_LIMIT_BIT = 2;
    localparam int ST_LAST_DIR_BIT = 3;

    // ************************************************
    // timing and arithmetic
    // ************************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int FILTER_STEP_PS = 10000000;
    localparam int FILTER_STEP_CYCLES = FILTER_STEP_PS / CLK_PERIOD_PS;
    localparam logic [10:0] FILTER_STEP_LAST = 11'(FILTER_STEP_CYCLES - 1);
    localparam int FILT_FRAC = 16;
    localparam int TENTHS_PER_UNIT = 10;
    localparam int SEC_PER_MIN = 60;
    localparam int LIMIT_FACTOR_INV = 4000;
    localparam int LIMIT_DIVISOR = SEC_PER_MIN * LIMIT_FACTOR_INV / TENTHS_PER_UNIT;

    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_HOLD = 2'b01,
        MODE_APPLY = 2'b10
    } comp_mode_t;

endpackage

/* File: verilog/backlash_compensation.sv */
// backlash compensation stage of the position-control path
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module backlash_compensation
    import backlash_comp_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // drive configuration
    input wire logic cfg_reload,
    input wire logic rotary_motor,
    input wire logic position_control,
    input wire logic fully_closed_loop,
    input wire logic [31:0] gear_ratio_numerator,
    input wire logic [31:0] gear_ratio_denominator,
    input wire logic [15:0] max_motor_speed,
    input wire logic [31:0] encoder_resolution,
    input wire logic [31:0] external_scale_pitch_count,
    // drive state
    input wire logic servo_on,
    input wire logic overtravel,
    input wire logic motor_stopped,
    input wire logic ref_pulse_present,
    // position reference from host, in encoder pulses
    input wire logic ref_valid,
    input wire logic signed [31:0] ref_increment,
    // feedback
    input wire logic signed [47:0] shaft_position,
    input wire logic signed [47:0] motor_encoder_count,
    // outputs
    output logic signed [47:0] drive_position,
    output logic signed [47:0] feedback_machine_position,
    output logic signed [47:0] divided_pulse_position,
    output logic signed [31:0] comp_applied_monitor,
    output logic [31:0] comp_limit_monitor,
    output logic comp_active
);

    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        logic [15:0] dir_pending;
        logic dir_active;
        logic signed [31:0] amount;
        logic [15:0] tc_pending;
        logic [15:0] tc_active;
        logic [10:0] tick_cnt;
        logic signed [47:0] filt;
        logic last_dir;
        logic signed [47:0] ref_accum;
        logic signed [47:0] drive_pos;
        logic signed [47:0] fb_pos;
        logic signed [47:0] div_pos;
        logic signed [31:0] applied;
        logic [31:0] limit;
        logic over_limit;
        comp_mode_t mode;
        logic active;
        logic [31:0] rdata;
    } state_t;

    state_t st_reg;
    state_t st_next;

    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
        addr_is = (a == ofs);
    endfunction

    // ************************************************
    // next state
    // ************************************************
    logic [95:0] lim_num;
    logic [95:0] lim_den;
    logic [95:0] lim_q;
    logic [31:0] res_sel;
    logic [31:0] amt_mag;
    logic [31:0] status;
    logic signed [47:0] target_fx;
    logic signed [47:0] diff;
    logic signed [47:0] step;
    logic signed [47:0] tc_s;
    logic signed [71:0] prod;
    logic signed [71:0] q_div;
    logic signed [71:0] half;
    logic signed [71:0] rnd;
    logic eligible;
    comp_mode_t mode_n;

    always_comb begin
        lim_num = '0;
        lim_den = '0;
        lim_q = '0;
        res_sel = '0;
        amt_mag = '0;
        status = '0;
        target_fx = '0;
        diff = '0;
        step = '0;
        tc_s = '0;
        prod = '0;
        q_div = '0;
        half = '0;
        rnd = '0;
        eligible = 1'b0;
        mode_n = MODE_OFF;
        st_next = st_reg;
        st_next.rdata = '0;

        // register writes
        if (reg_wr) begin
            if (addr_is(reg_addr, OFS_DIRECTION)) begin
                st_next.dir_pending = reg_wdata[15:0];
            end
            if (addr_is(reg_addr, OFS_AMOUNT)) begin
                // out-of-range writes saturate rather than wrap
                if ($signed(reg_wdata) > AMOUNT_MAX) begin
                    st_next.amount = AMOUNT_MAX;
                end else if ($signed(reg_wdata) < AMOUNT_MIN) begin
                    st_next.amount = AMOUNT_MIN;
                end else begin
                    st_next.amount = $signed(reg_wdata);
                end
            end
            if (addr_is(reg_addr, OFS_TIME_CONST)) begin
                st_next.tc_pending = reg_wdata[15:0];
            end
        end

        // status word
        status[ST_ACTIVE_DIR_BIT] = st_reg.dir_active;
        status[ST_COMP_ON_BIT] = st_reg.active;
        status[ST_OVER_LIMIT_BIT] = st_reg.over_limit;
        status[ST_LAST_DIR_BIT] = st_reg.last_dir;

        // register reads, data in the following cycle
        if (reg_rd) begin
            if (addr_is(reg_addr, OFS_DIRECTION)) begin
                st_next.rdata = {16'h0000, st_reg.dir_pending};
            end else if (addr_is(reg_addr, OFS_AMOUNT)) begin
                st_next.rdata = st_reg.amount;
            end else if (addr_is(reg_addr, OFS_TIME_CONST)) begin
                st_next.rdata = {16'h0000, st_reg.tc_pending};
            end else if (addr_is(reg_addr, OFS_APPLIED)) begin
                st_next.rdata = st_reg.applied;
            end else if (addr_is(reg_addr, OFS_LIMIT)) begin
                st_next.rdata = st_reg.limit;
            end else if (addr_is(reg_addr, OFS_STATUS)) begin
                st_next.rdata = status;
            end else begin
                st_next.rdata = '0;
            end
        end

        // direction only changes on a restart of the settings
        if (cfg_reload) begin
            st_next.dir_active = st_reg.dir_pending[0];
        end

        // deferred so a move in progress keeps its filter response
        if (!ref_pulse_present && motor_stopped) begin
            st_next.tc_active = st_reg.tc_pending;
        end

        // reverse increment reads as DIR_REVERSE, zero keeps the last one
        if (ref_valid && (ref_increment != 32'sh00000000)) begin
            st_next.last_dir = (ref_increment < 0) ? DIR_REVERSE : DIR_FORWARD;
        end

        // setting limit in tenths of a reference unit
        res_sel = fully_closed_loop ? external_scale_pitch_count : encoder_resolution;
        lim_num = 96'(gear_ratio_denominator) * 96'(max_motor_speed) * 96'(res_sel);
        lim_den = 96'(gear_ratio_numerator) * 96'(LIMIT_DIVISOR);
        if (lim_den == '0) begin
            lim_q = '1;
        end else begin
            lim_q = lim_num / lim_den;
        end
        st_next.limit = (|lim_q[95:32]) ? 32'hFFFFFFFF : lim_q[31:0];
        amt_mag = (st_reg.amount < 0) ? 32'(-st_reg.amount) : 32'(st_reg.amount);
        st_next.over_limit = (amt_mag > st_reg.limit);

        // operating mode
        eligible = rotary_motor && position_control;
        if (!eligible || !servo_on || overtravel || st_reg.over_limit) begin
            mode_n = MODE_OFF;
        end else if (st_reg.last_dir == st_reg.dir_active) begin
            mode_n = MODE_APPLY;
        end else begin
            mode_n = MODE_HOLD;
        end
        st_next.mode = mode_n;
        // registered beside the mode so the output leaves a flip-flop
        st_next.active = (mode_n == MODE_APPLY);

        // first-order lag, one step every 0.01 ms
        if (st_reg.tick_cnt == FILTER_STEP_LAST) begin
            st_next.tick_cnt = '0;
        end else begin
            st_next.tick_cnt = st_reg.tick_cnt + 11'h001;
        end
        if (st_reg.mode == MODE_APPLY) begin
            target_fx = 48'(st_reg.amount) <<< FILT_FRAC;
        end else begin
            target_fx = '0;
        end
        tc_s = $signed({32'h00000000, st_reg.tc_active});
        case (st_reg.mode)
            MODE_OFF: begin
                // removed at once, the reference position jumps by the amount
                st_next.filt = '0;
            end
            MODE_HOLD, MODE_APPLY: begin
                if (st_reg.tc_active == 16'h0000) begin
                    st_next.filt = target_fx;
                end else if (st_reg.tick_cnt == FILTER_STEP_LAST) begin
                    diff = target_fx - st_reg.filt;
                    step = diff / tc_s;
                    // keep creeping when the quotient truncates to zero
                    if ((step == 48'sh0) && (diff > 0)) begin
                        step = 48'sh1;
                    end else if ((step == 48'sh0) && (diff < 0)) begin
                        step = -48'sh1;
                    end
                    st_next.filt = st_reg.filt + step;
                end
            end
            default: begin
                st_next.filt = '0;
            end
        endcase
        st_next.applied = st_reg.filt[FILT_FRAC +: 32];

        // amount in encoder pulses, rounded half away from zero
        prod = 72'(st_reg.applied) * $signed({40'h0000000000, gear_ratio_numerator});
        q_div = $signed({40'h0000000000, gear_ratio_denominator}) * 72'(TENTHS_PER_UNIT);
        half = q_div >>> 1;
        if (q_div == 72'sh0) begin
            rnd = '0;
        end else if (prod < 0) begin
            rnd = (prod - half) / q_div;
        end else begin
            rnd = (prod + half) / q_div;
        end

        // reference path and feedback path
        if (ref_valid) begin
            st_next.ref_accum = st_reg.ref_accum + 48'(ref_increment);
        end
        st_next.drive_pos = st_reg.ref_accum + $signed(rnd[47:0]);
        st_next.fb_pos = shaft_position - 48'(st_reg.applied);
        st_next.div_pos = motor_encoder_count;
    end

    // ************************************************
    // registers
    // ************************************************
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_reg <= '0;
            st_reg.dir_pending <= DIR_RESET;
            st_reg.dir_active <= DIR_RESET[0];
            st_reg.amount <= AMOUNT_RESET;
            st_reg.tc_pending <= TC_RESET;
            st_reg.tc_active <= TC_RESET;
            st_reg.last_dir <= DIR_FORWARD;
            st_reg.mode <= MODE_OFF;
        end else begin
            st_reg <= st_next;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    assign reg_rdata = st_reg.rdata;
    assign drive_position = st_reg.drive_pos;
    assign feedback_machine_position = st_reg.fb_pos;
    assign divided_pulse_position = st_reg.div_pos;
    assign comp_applied_monitor = st_reg.applied;
    assign comp_limit_monitor = st_reg.limit;
    assign comp_active = st_reg.active;

endmodule // backlash_compensation

/* File: verif/host_ref_model.sv */
// host controller model sending position reference bursts
`timescale 1ns/1ps
module host_ref_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // burst request
    input wire logic start,
    input wire logic rev,
    input wire logic [7:0] steps,
    // reference stream
    output logic ref_valid,
    output logic signed [31:0] ref_increment,
    output logic busy
);
    logic [7:0] left_reg;
    logic signed [31:0] last_reg;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            left_reg <= 8'h00;
            last_reg <= 32'sh0;
        end else if (start) begin
            left_reg <= steps;
        end else if (busy) begin
            left_reg <= left_reg - 8'h01;
            last_reg <= ref_increment;
        end
    end
    assign busy = (left_reg != 8'h00);
    assign ref_valid = busy;
    // idle value is the inverse of the last step, never a stale copy
    assign ref_increment = busy ? (rev ? -32'sh5 : 32'sh5) : ~last_reg;
endmodule // host_ref_model

/* File: verif/backlash_compensation_assertions.sv */
// port checker of the backlash compensation stage
`timescale 1ns/1ps
module backlash_compensation_assertions (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // watched ports
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic rotary_motor,
    input wire logic position_control,
    input wire logic servo_on,
    input wire logic overtravel,
    input wire logic signed [47:0] shaft_position,
    input wire logic signed [47:0] motor_encoder_count,
    input wire logic signed [47:0] feedback_machine_position,
    input wire logic signed [47:0] divided_pulse_position,
    input wire logic signed [31:0] comp_applied_monitor,
    input wire logic comp_active
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_reset_clears: assert property (disable iff (1'b0)
        sys_rst |=> !comp_active && comp_applied_monitor == 32'sh0)
        else $error("reset left compensation applied");
    a_read_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    a_rotary_only: assert property (!rotary_motor [*3] |-> !comp_active)
        else $error("compensation without rotary motor");
    a_posctl_only: assert property (!position_control [*3] |-> !comp_active)
        else $error("compensation outside position control");
    a_servo_off: assert property ($fell(servo_on) |-> ##[1:2] !comp_active)
        else $error("compensation kept at servo off");
    a_overtravel_off: assert property (overtravel [*3] |-> !comp_active)
        else $error("compensation during overtravel");
    a_divided_delay: assert property (!$past(sys_rst) |->
        divided_pulse_position == $past(motor_encoder_count))
        else $error("divided output not the encoder count");
    a_feedback_sub: assert property (!$past(sys_rst) |->
        feedback_machine_position == $past(shaft_position) - $past(comp_applied_monitor))
        else $error("feedback not shaft minus applied");
endmodule // backlash_compensation_assertions
bind backlash_compensation backlash_compensation_assertions chk (
    .core_clk, .sys_rst, .reg_rd, .reg_rdata, .rotary_motor, .position_control, .servo_on,
    .overtravel, .shaft_position, .motor_encoder_count, .feedback_machine_position,
    .divided_pulse_position, .comp_applied_monitor, .comp_active
);

/* File: verif/backlash_compensation_tb.sv */
// self-checking bench of the backlash compensation stage
`timescale 1ns/1ps
module backlash_compensation_tb
    import backlash_comp_pkg::*;
;
    logic core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, cfg_reload = 1'b0;
    logic rotary_motor = 1'b0, position_control = 1'b1, fully_closed_loop = 1'b0;
    logic servo_on = 1'b1, overtravel = 1'b0, start = 1'b0, rev = 1'b0;
    logic ref_valid, busy, comp_active;
    logic [7:0] reg_addr = 8'h00, steps = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, comp_limit_monitor, rdv;
    logic [31:0] gear_ratio_numerator = 32'h4, gear_ratio_denominator = 32'h1;
    logic [15:0] max_motor_speed = 16'h1770;
    logic [31:0] encoder_resolution = 32'h0100_0000, external_scale_pitch_count = 32'h0001_F400;
    logic signed [31:0] ref_increment, comp_applied_monitor, amt = 32'sh0;
    logic signed [47:0] shaft_position = 48'sh3000, motor_encoder_count = 48'sh0, acc = 48'sh0;
    logic signed [47:0] drive_position, feedback_machine_position, divided_pulse_position, pls;
    int error_cnt = 0, comparisons = 0;
    wire logic motor_stopped = !busy;
    wire logic ref_pulse_present = busy;
    backlash_compensation DUT (
        .core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .cfg_reload, .rotary_motor, .position_control, .fully_closed_loop,
        .gear_ratio_numerator, .gear_ratio_denominator, .max_motor_speed,
        .encoder_resolution, .external_scale_pitch_count, .servo_on, .overtravel,
        .motor_stopped, .ref_pulse_present, .ref_valid, .ref_increment, .shaft_position,
        .motor_encoder_count, .drive_position, .feedback_machine_position,
        .divided_pulse_position, .comp_applied_monitor, .comp_limit_monitor, .comp_active
    );
    host_ref_model host (
        .core_clk, .sys_rst, .start, .rev, .steps, .ref_valid, .ref_increment, .busy
    );
    initial forever #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) motor_encoder_count <= motor_encoder_count + 48'sh3;
    task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic settle;
        repeat (12) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        rdv = reg_rdata;
    endtask
    task automatic move(input logic r, input logic [7:0] n);
        int k;
        @(posedge core_clk);
        rev <= r;
        steps <= n;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        acc = r ? acc - 48'(5 * n) : acc + 48'(5 * n);
        #1;
        for (k = 0; k < 300 && busy === 1'b1; k++) @(posedge core_clk);
        settle();
    endtask
    task automatic state(input logic on);
        chk("active", 48'(comp_active), 48'(on));
        chk("applied", 48'(comp_applied_monitor), on ? 48'(amt) : 48'h0);
        chk("drive", drive_position, on ? acc + pls : acc);
        chk("fb", feedback_machine_position, shaft_position - (on ? amt : 32'sh0));
    endtask
    task automatic t_regs;
        rd(OFS_DIRECTION);
        chk("direction", 48'(rdv), 48'(DIR_RESET));
        rd(OFS_TIME_CONST);
        chk("time_const", 48'(rdv), 48'h0);
        rd(8'h20);
        chk("unmapped", 48'(rdv), 48'h0);
        wr(OFS_AMOUNT, 32'h0009_27C0);
        rd(OFS_AMOUNT);
        chk("amount_hi", 48'(rdv), 48'h7_A120);
        wr(OFS_AMOUNT, 32'hFFF6_D840);
        rd(OFS_AMOUNT);
        chk("amount_lo", 48'(rdv), 48'hFFF8_5EE0);
    endtask
    task automatic t_apply;
        @(posedge core_clk);
        rotary_motor <= 1'b1;
        amt = 32'sh0001_0000;
        pls = 48'sh6666;
        wr(OFS_AMOUNT, amt);
        move(1'b0, 8'h0A);
        state(1'b1);
        move(1'b1, 8'h04);
        state(1'b0);
        move(1'b0, 8'h03);
        state(1'b1);
    endtask
    task automatic t_states;
        int k;
        for (k = 0; k < 4; k++) begin
            @(posedge core_clk);
            servo_on <= (k != 0);
            overtravel <= (k == 1);
            position_control <= (k != 2);
            rotary_motor <= (k != 3);
            shaft_position <= shaft_position + 48'sh100;
            settle();
            state(1'b0);
            @(posedge core_clk);
            {servo_on, overtravel, position_control, rotary_motor} <= 4'hB;
            settle();
            state(1'b1);
        end
    endtask
    task automatic t_limit;
        chk("limit", 48'(comp_limit_monitor), 48'h10_0000);
        @(posedge core_clk);
        fully_closed_loop <= 1'b1;
        settle();
        chk("limit_fc", 48'(comp_limit_monitor), 48'h1F40);
        state(1'b0);
        wr(OFS_AMOUNT, 32'h1F41);
        settle();
        chk("active", 48'(comp_active), 48'h0);
        amt = 32'sh1F40;
        pls = 48'shC80;
        wr(OFS_AMOUNT, amt);
        settle();
        state(1'b1);
        rd(OFS_LIMIT);
        chk("limit_reg", 48'(rdv), 48'h1F40);
        rd(OFS_APPLIED);
        chk("applied_reg", 48'(rdv), 48'h1F40);
        rd(OFS_STATUS);
        chk("status", 48'(rdv), 48'h2);
    endtask
    task automatic t_dirsel;
        wr(OFS_DIRECTION, 32'h1);
        move(1'b1, 8'h02);
        chk("active", 48'(comp_active), 48'h0);
        @(posedge core_clk);
        cfg_reload <= 1'b1;
        @(posedge core_clk);
        cfg_reload <= 1'b0;
        settle();
        chk("active", 48'(comp_active), 48'h1);
        move(1'b0, 8'h02);
        chk("active", 48'(comp_active), 48'h0);
    endtask
    task automatic t_filter;
        int k;
        @(posedge core_clk);
        rev <= 1'b1;
        steps <= 8'h3C;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        acc = acc - 48'sd300;
        // time constant written mid-move must wait, so the amount still passes unfiltered
        wr(OFS_TIME_CONST, 32'h0000_0002);
        wr(OFS_AMOUNT, 32'h0000_0FA0);
        repeat (8) @(posedge core_clk);
        #1;
        chk("applied_busy", 48'(comp_applied_monitor), 48'h0FA0);
        for (k = 0; k < 300 && busy === 1'b1; k++) @(posedge core_clk);
        settle();
        wr(OFS_AMOUNT, 32'h0000_1F40);
        for (k = 0; k < 2100 && comp_applied_monitor == 32'sh0FA0; k++) @(posedge core_clk);
        repeat (2) @(posedge core_clk);
        #1;
        chk("lag_first", 48'(comp_applied_monitor), 48'h1770);
        for (k = 0; k < 2100 && comp_applied_monitor == 32'sh1770; k++) @(posedge core_clk);
        repeat (2) @(posedge core_clk);
        #1;
        chk("lag_second", 48'(comp_applied_monitor), 48'h1B58);
    endtask
    // two filter steps take about 4000 cycles, the rest a few hundred
    initial begin
        repeat (12000) @(posedge core_clk);
        error_cnt++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        t_regs();
        t_apply();
        t_states();
        t_limit();
        t_dirsel();
        t_filter();
        conclude();
    end
endmodule // backlash_compensation_tb
